// ### pkg/actc_pkg.sv
package actc_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [15:0] IDX_PCH = 16'h1D1F;
  localparam logic [15:0] IDX_CON3 = 16'h1D29;
  localparam logic [15:0] IDX_STAT = 16'h1D2A;
  localparam logic [15:0] IDX_REF = 16'h1D2B;
  localparam logic [15:0] IDX_CLK = 16'h1D2D;
  localparam logic [15:0] IDX_CON2 = 16'h1D28;
  localparam logic [15:0] IDX_CON1 = 16'h1D27;
  localparam logic [15:0] IDX_MISC = 16'h1D40;
  localparam logic [15:0] IDX_UTH = 16'h1D41;
  localparam logic [15:0] IDX_LTH = 16'h1D42;
  localparam logic [15:0] IDX_STPT = 16'h1D43;
  localparam logic [15:0] IDX_ERR = 16'h1D44;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int unsigned CLR_CYCLES = 4;
  localparam int unsigned DIV_MSB = 6;
  typedef struct packed {
    logic [2:0] formula;
    logic stop_on_thr;
    logic [2:0] tmode;
  } actc_con3_s;
  typedef struct packed {
    logic [15:0] result;
    logic [15:0] previous;
    logic [15:0] filter;
  } actc_sample_s;
endpackage

// ### rtl/actc_core.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
// Contract
// - Clear command holds until clearing completes.
// - Shift codes 000 and 111 are reserved.
// - Code 101 filter-setpoint; 100 previous-filter.
// - Codes 010/001 subtract previous when double.
// - Code 000 result-previous; others reserved.
// - Double with result source: every second.
// - Stop-on-threshold clears run in continuous mode.
// - Without stop bit, run bit stays set.
// - Threshold modes always, never, upper tests.
// - Modes outside window and inside window.
// - Overflow flag set, cleared by software/hardware.
// - Upper flag shows error above upper.
// - Lower flag shows error below lower.
// - Updated flag set on computation, sticky.
// - Updated clear ignored while stage is suspended.
// - Stage field encodes idle and six stages.
// - Stage shows suspended between paired triggers when not continuous.
// - Divider gives system clock over 2(n+1).
// - Divider only applies with system clock source.
// - Reference field selects fixed, pin, supply.
// - Positive input field selects analog source.
// - Double enable pairs conversions before computing.
module actc_core (
  // APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter side, same clock.
  input wire logic conv_done,
  input wire logic [2:0] conv_stage,
  input wire actc_pkg::actc_sample_s sample,
  input wire logic accum_overflow,
  input wire logic clear_done,
  // Controls to the converter.
  output logic run,
  output logic run_clear,
  output logic threshold_irq,
  output logic accumulator_clear_cmd,
  output logic adc_clk_en,
  output logic [1:0] positive_reference_field,
  output logic [5:0] positive_input_field,
  output logic [2:0] shift_select,
  output logic shift_valid
);
  ////////////////////////////////////////////////////////////////////////////
  actc_pkg::actc_con3_s con3;
  logic [5:0] div_sel;
  logic rc_source;
  logic double_sample_enable;
  logic previous_source_select;
  logic repeat_conversion;
  logic [15:0] upper_threshold;
  logic [15:0] lower_threshold;
  logic [15:0] setpoint_value;
  logic [15:0] error_value;
  logic accumulator_overflow;
  logic computation_updated_flag;
  logic second_half;
  logic [2:0] stage;
  logic [6:0] div_cnt;
  logic [$clog2(actc_pkg::CLR_CYCLES+1)-1:0] clr_cnt;
  logic [15:0] idx;
  logic wr;
  logic rd_ok;
  logic compute;
  logic [16:0] next_err;
  logic err_ovf;
  logic above_upper_flag;
  logic below_lower_flag;
  logic thr_hit;
  logic [31:0] next_rdata;
  logic [1:0] reference_raw;
  logic wr_pch;
  logic wr_con1;
  logic wr_con2;
  logic wr_con3;
  logic wr_stat;
  logic wr_ref;
  logic wr_clk;
  logic wr_misc;
  logic wr_uth;
  logic wr_lth;
  logic wr_stpt;

  assign idx = paddr[17:2];
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rd_ok;
  assign positive_reference_field = (reference_raw == 2'b01) ? 2'b00 : reference_raw;
  ////////////////////////////////////////////////////////////////////////////
  // Write strobes, decoded once so every register process sees the same access.
  assign wr_pch = wr && (idx == actc_pkg::IDX_PCH);
  assign wr_con1 = wr && (idx == actc_pkg::IDX_CON1);
  assign wr_con2 = wr && (idx == actc_pkg::IDX_CON2);
  assign wr_con3 = wr && (idx == actc_pkg::IDX_CON3);
  assign wr_stat = wr && (idx == actc_pkg::IDX_STAT);
  assign wr_ref = wr && (idx == actc_pkg::IDX_REF);
  assign wr_clk = wr && (idx == actc_pkg::IDX_CLK);
  assign wr_misc = wr && (idx == actc_pkg::IDX_MISC);
  assign wr_uth = wr && (idx == actc_pkg::IDX_UTH);
  assign wr_lth = wr && (idx == actc_pkg::IDX_LTH);
  assign wr_stpt = wr && (idx == actc_pkg::IDX_STPT);
  ////////////////////////////////////////////////////////////////////////////
  // Register writes, one process per register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con3 <= '0;
    end else if (wr_con3) begin
      con3 <= pwdata[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_sel <= '0;
    end else if (wr_clk) begin
      div_sel <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_raw <= '0;
    end else if (wr_ref) begin
      reference_raw <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      positive_input_field <= '0;
    end else if (wr_pch) begin
      positive_input_field <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_sample_enable <= 1'b0;
    end else if (wr_con1) begin
      double_sample_enable <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      previous_source_select <= 1'b0;
      shift_select <= '0;
    end else if (wr_con2) begin
      previous_source_select <= pwdata[7];
      shift_select <= pwdata[6:4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_source <= 1'b0;
      repeat_conversion <= 1'b0;
    end else if (wr_misc) begin
      rc_source <= pwdata[0];
      repeat_conversion <= pwdata[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_threshold <= actc_pkg::RST_WORD;
    end else if (wr_uth) begin
      upper_threshold <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_threshold <= actc_pkg::RST_WORD;
    end else if (wr_lth) begin
      lower_threshold <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setpoint_value <= actc_pkg::RST_WORD;
    end else if (wr_stpt) begin
      setpoint_value <= pwdata[15:0];
    end
  end

  // Software's repeat count is trusted to be a power of two matching the shift.
  assign shift_valid = (shift_select != 3'b000) && (shift_select != 3'b111);
  ////////////////////////////////////////////////////////////////////////////
  // Accumulator clear: held set until the converter confirms and a floor has elapsed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator_clear_cmd <= 1'b0;
      clr_cnt <= '0;
    end else if (wr_con2 && pwdata[3]) begin
      accumulator_clear_cmd <= 1'b1;
      clr_cnt <= '0;
    end else if (accumulator_clear_cmd) begin
      if (clear_done && clr_cnt >= ($bits(clr_cnt))'(actc_pkg::CLR_CYCLES)) begin
        accumulator_clear_cmd <= 1'b0;
      end else if (clr_cnt < ($bits(clr_cnt))'(actc_pkg::CLR_CYCLES)) begin
        clr_cnt <= clr_cnt + 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Clock divider; the RC source bypasses it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (rc_source || div_cnt >= {div_sel, 1'b1}) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign adc_clk_en = rc_source | (div_cnt == {div_sel, 1'b1});
  ////////////////////////////////////////////////////////////////////////////
  // Pairing: with double sampling, only the second conversion computes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_half <= 1'b0;
    end else if (!double_sample_enable) begin
      second_half <= 1'b0;
    end else if (conv_done) begin
      second_half <= ~second_half;
    end
  end
  assign compute = conv_done & (~double_sample_enable | second_half);

  // Stage field: suspended between paired triggers when not continuous.
  always_comb begin
    if (double_sample_enable && !repeat_conversion && second_half && conv_stage == 3'b000) begin
      stage = 3'b100;
    end else begin
      stage = conv_stage;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Error formula, one bit wider to catch overflow.
  always_comb begin
    logic [16:0] r;
    logic [16:0] p;
    logic [16:0] f;
    logic [16:0] s;
    logic [16:0] base;
    r = {sample.result[15], sample.result};
    p = {sample.previous[15], sample.previous};
    f = {sample.filter[15], sample.filter};
    s = {setpoint_value[15], setpoint_value};
    base = double_sample_enable ? (r - p) : r;
    case (con3.formula)
      3'b101: next_err = f - s;
      3'b100: next_err = p - f;
      3'b010: next_err = base - f;
      3'b001: next_err = base - s;
      3'b000: next_err = r - p;
      default: next_err = 17'h00000;
    endcase
  end
  assign err_ovf = next_err[16] ^ next_err[15];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_value <= actc_pkg::RST_WORD;
    end else if (compute) begin
      error_value <= next_err[15:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Threshold tests on the fresh error.
  logic n_above;
  logic n_below;
  assign n_above = $signed(next_err[15:0]) > $signed(upper_threshold);
  assign n_below = $signed(next_err[15:0]) < $signed(lower_threshold);
  assign above_upper_flag = $signed(error_value) > $signed(upper_threshold);
  assign below_lower_flag = $signed(error_value) < $signed(lower_threshold);
  always_comb begin
    case (con3.tmode)
      3'b111: thr_hit = 1'b1;
      3'b110: thr_hit = n_above;
      3'b101: thr_hit = ~n_above;
      3'b100: thr_hit = n_below | n_above;
      3'b011: thr_hit = ~n_below & ~n_above &
        ($signed(next_err[15:0]) != $signed(lower_threshold)) &
        ($signed(next_err[15:0]) != $signed(upper_threshold));
      3'b010: thr_hit = ~n_below;
      3'b001: thr_hit = n_below;
      default: thr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      threshold_irq <= 1'b0;
      run_clear <= 1'b0;
    end else begin
      threshold_irq <= compute & thr_hit;
      // Run bit only stopped by hardware in continuous mode with the stop bit.
      run_clear <= compute & thr_hit & repeat_conversion & con3.stop_on_thr;
    end
  end

  // Run bit: software sets via misc bit 2, hardware clears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
    end else if (run_clear) begin
      run <= 1'b0;
    end else if (wr_misc) begin
      run <= pwdata[2];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Status flags; hardware set wins over software clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator_overflow <= 1'b0;
    end else if ((compute && err_ovf) || accum_overflow) begin
      accumulator_overflow <= 1'b1;
    end else if (accumulator_clear_cmd || (wr_stat && !pwdata[7])) begin
      accumulator_overflow <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      computation_updated_flag <= 1'b0;
    end else if (compute || accum_overflow) begin
      computation_updated_flag <= 1'b1;
    end else if (wr_stat && !pwdata[4] && stage != 3'b100) begin
      computation_updated_flag <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read mux.
  always_comb begin
    rd_ok = 1'b1;
    next_rdata = 32'h00000000;
    case (idx)
      actc_pkg::IDX_CON3: next_rdata = {25'h0, con3};
      actc_pkg::IDX_STAT: next_rdata = {24'h0, accumulator_overflow, above_upper_flag,
        below_lower_flag, computation_updated_flag, 1'b0, stage};
      actc_pkg::IDX_CLK: next_rdata = {26'h0, div_sel};
      actc_pkg::IDX_REF: next_rdata = {30'h0, reference_raw};
      actc_pkg::IDX_PCH: next_rdata = {26'h0, positive_input_field};
      actc_pkg::IDX_CON1: next_rdata = {31'h0, double_sample_enable};
      actc_pkg::IDX_CON2: next_rdata = {24'h0, previous_source_select, shift_select,
        accumulator_clear_cmd, 3'h0};
      actc_pkg::IDX_MISC: next_rdata = {29'h0, run, repeat_conversion, rc_source};
      actc_pkg::IDX_UTH: next_rdata = {16'h0, upper_threshold};
      actc_pkg::IDX_LTH: next_rdata = {16'h0, lower_threshold};
      actc_pkg::IDX_STPT: next_rdata = {16'h0, setpoint_value};
      actc_pkg::IDX_ERR: next_rdata = {16'h0, error_value};
      default: rd_ok = 1'b0;
    endcase
  end
  // Read data is latched in the setup phase, so the access phase returns a settled flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= next_rdata;
    end
  end
endmodule

// ### bench/actc_chk_sva.sv
`timescale 1ns/1ps
module actc_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus and converter inputs.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic conv_done,
  input wire logic clear_done,
  // Controls under watch.
  input wire logic run,
  input wire logic run_clear,
  input wire logic threshold_irq,
  input wire logic accumulator_clear_cmd,
  input wire logic [1:0] positive_reference_field,
  input wire logic [2:0] shift_select,
  input wire logic shift_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  property p_clr_hold; $rose(accumulator_clear_cmd) |-> accumulator_clear_cmd [*3]; endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("clear command dropped early");
  property p_clr_end; $fell(accumulator_clear_cmd) |-> $past(clear_done); endproperty
  a_clr_end: assert property (p_clr_end) else $error("clear ended without done");
  property p_shift; shift_valid == (shift_select != 3'h0 && shift_select != 3'h7); endproperty
  a_shift: assert property (p_shift) else $error("shift validity wrong");
  property p_stop_run; run_clear |=> !run; endproperty
  a_stop_run: assert property (p_stop_run) else $error("run kept after stop");
  property p_stop_cause; run_clear |-> threshold_irq; endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("stop without threshold hit");
  property p_run_fall;
    $fell(run) |-> $past(run_clear) || $past(psel && penable && pwrite);
  endproperty
  a_run_fall: assert property (p_run_fall) else $error("run cleared without cause");
  property p_irq_cause; threshold_irq |-> $past(conv_done) || $past(conv_done, 2); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without computation");
  property p_ref; positive_reference_field != 2'h1; endproperty
  a_ref: assert property (p_ref) else $error("reserved reference driven");
endmodule
bind actc_core actc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .conv_done(conv_done), .clear_done(clear_done), .run(run),
  .run_clear(run_clear), .threshold_irq(threshold_irq),
  .accumulator_clear_cmd(accumulator_clear_cmd), .shift_valid(shift_valid),
  .positive_reference_field(positive_reference_field), .shift_select(shift_select));

// ### bench/actc_core_bench.sv
`timescale 1ns/1ps
module actc_core_bench;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic conv_done = 1'h0, accum_overflow = 1'h0, clear_done = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [2:0] conv_stage = 3'h0, shift_select;
  actc_pkg::actc_sample_s sample = '0;
  logic pready, pslverr, run, run_clear, threshold_irq, accumulator_clear_cmd, adc_clk_en;
  logic shift_valid, irq, err, stp;
  logic [1:0] positive_reference_field, fl;
  logic [5:0] positive_input_field;
  int failures = 0, tests_run = 0, n;
  // Errors -60, -50, 0, 50, 60 straddle both thresholds and hit each boundary.
  logic [15:0] tv [5] = '{16'hFFC4, 16'hFFCE, 16'h0000, 16'h0032, 16'h003C};
  logic [15:0] ev [8] = '{16'h0046, 16'h005D, 16'h005A, 16'h0000,
    16'h0014, 16'h0003, 16'h0000, 16'h0000};
  actc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .conv_stage(conv_stage), .sample(sample), .run(run),
    .accum_overflow(accum_overflow), .clear_done(clear_done), .run_clear(run_clear),
    .threshold_irq(threshold_irq), .accumulator_clear_cmd(accumulator_clear_cmd),
    .adc_clk_en(adc_clk_en), .positive_reference_field(positive_reference_field),
    .positive_input_field(positive_input_field), .shift_select(shift_select),
    .shift_valid(shift_valid));
  ////////////////////////////////////////////////////////////
  initial begin
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {14'h0000, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'h0, idx, 32'h0);
    chk(rd & mask, exp);
  endtask
  // Filter is held at 10 so every formula has a distinct result.
  task automatic conv(input logic [15:0] r, input logic [15:0] p);
    @(posedge pclk);
    conv_done <= 1'h1;
    sample <= '{r, p, 16'h000A};
    @(posedge pclk);
    conv_done <= 1'h0;
    irq = 1'h0;
    stp = 1'h0;
    repeat (4) @(posedge pclk) begin
      irq = irq | threshold_irq;
      stp = stp | run_clear;
    end
  endtask
  function automatic logic irq_exp(input int m, input int e);
    case (m)
      7: return 1'h1;
      6: return e > 50;
      5: return e <= 50;
      4: return e < -50 || e > 50;
      3: return e > -50 && e < 50;
      2: return e >= -50;
      1: return e < -50;
      default: return 1'h0;
    endcase
  endfunction
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    rdc(actc_pkg::IDX_CON3, 32'hFF, 32'h0);
    rdc(actc_pkg::IDX_STAT, 32'hFF, 32'h0);
    apb(1'h0, 16'h1D30, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("Test reset done");
    apb(1'h1, actc_pkg::IDX_STPT, 32'h7);
    for (int c = 0; c < 8; c++) begin
      apb(1'h1, actc_pkg::IDX_CON3, c << 4);
      conv(16'h0064, 16'h001E);
      rdc(actc_pkg::IDX_ERR, 32'hFFFF, {16'h0, ev[c]});
    end
    apb(1'h1, actc_pkg::IDX_UTH, 32'h32);
    apb(1'h1, actc_pkg::IDX_LTH, 32'hFFCE);
    for (int m = 0; m < 8; m++) begin
      apb(1'h1, actc_pkg::IDX_CON3, m);
      foreach (tv[i]) begin
        conv(tv[i], 16'h0);
        chk(irq, irq_exp(m, $signed(tv[i])));
        fl = {irq_exp(6, $signed(tv[i])), irq_exp(1, $signed(tv[i]))};
        if (m == 0) rdc(actc_pkg::IDX_STAT, 32'h60, {25'h0, fl, 5'h0});
      end
    end
    $display("Test compute done");
    apb(1'h1, actc_pkg::IDX_CON1, 32'h1);
    apb(1'h1, actc_pkg::IDX_CON3, 32'h20);
    conv(16'h0064, 16'h001E);
    apb(1'h1, actc_pkg::IDX_STAT, 32'h0);
    rdc(actc_pkg::IDX_STAT, 32'h17, 32'h14);
    conv(16'h0064, 16'h001E);
    rdc(actc_pkg::IDX_ERR, 32'hFFFF, 32'h3C);
    apb(1'h1, actc_pkg::IDX_STAT, 32'h0);
    rdc(actc_pkg::IDX_STAT, 32'h17, 32'h0);
    apb(1'h1, actc_pkg::IDX_CON1, 32'h0);
    apb(1'h1, actc_pkg::IDX_MISC, 32'h6);
    apb(1'h1, actc_pkg::IDX_CON3, 32'hE);
    conv(16'h0005, 16'h0);
    chk(run, 1'h1);
    chk(stp, 1'h0);
    apb(1'h1, actc_pkg::IDX_CON3, 32'hF);
    conv(16'h0005, 16'h0);
    chk(run, 1'h0);
    chk(stp, 1'h1);
    apb(1'h1, actc_pkg::IDX_CON3, 32'h7);
    apb(1'h1, actc_pkg::IDX_MISC, 32'h6);
    conv(16'h0005, 16'h0);
    chk(run, 1'h1);
    chk(stp, 1'h0);
    apb(1'h1, actc_pkg::IDX_MISC, 32'h2);
    rdc(actc_pkg::IDX_MISC, 32'h4, 32'h0);
    $display("Test pairing and stop done");
    // A full-scale difference overflows the error word and must raise the flag.
    apb(1'h1, actc_pkg::IDX_CON3, 32'h0);
    conv(16'h7FFF, 16'h8000);
    rdc(actc_pkg::IDX_STAT, 32'h80, 32'h80);
    apb(1'h1, actc_pkg::IDX_STAT, 32'h10);
    rdc(actc_pkg::IDX_STAT, 32'h80, 32'h0);
    @(posedge pclk) accum_overflow <= 1'h1;
    @(posedge pclk) accum_overflow <= 1'h0;
    rdc(actc_pkg::IDX_STAT, 32'h80, 32'h80);
    apb(1'h1, actc_pkg::IDX_CON2, 32'h8);
    // The converter is slow to confirm, so the command must ride out the wait.
    repeat (10) @(posedge pclk);
    rdc(actc_pkg::IDX_CON2, 32'h8, 32'h8);
    clear_done <= 1'h1;
    repeat (6) @(posedge pclk);
    chk(accumulator_clear_cmd, 1'h0);
    clear_done <= 1'h0;
    rdc(actc_pkg::IDX_STAT, 32'h80, 32'h0);
    $display("Test clear done");
    apb(1'h1, actc_pkg::IDX_PCH, 32'h3F);
    apb(1'h1, actc_pkg::IDX_REF, 32'h3);
    apb(1'h1, actc_pkg::IDX_CON2, 32'h30);
    @(posedge pclk);
    chk({positive_input_field, positive_reference_field}, 8'hFF);
    chk({shift_select, shift_valid}, 4'h7);
    rdc(actc_pkg::IDX_PCH, 32'hFF, 32'h3F);
    apb(1'h1, actc_pkg::IDX_REF, 32'h1);
    apb(1'h1, actc_pkg::IDX_CON2, 32'h70);
    @(posedge pclk);
    chk({positive_reference_field, shift_valid}, 3'h0);
    conv_stage <= 3'h5;
    rdc(actc_pkg::IDX_STAT, 32'h7, 32'h5);
    conv_stage <= 3'h0;
    apb(1'h1, actc_pkg::IDX_CLK, 32'h2);
    repeat (2) do @(posedge pclk); while (adc_clk_en !== 1'h1);
    n = 0;
    do @(posedge pclk) n++; while (adc_clk_en !== 1'h1);
    chk(n, 6);
    apb(1'h1, actc_pkg::IDX_MISC, 32'h1);
    repeat (3) @(posedge pclk) chk(adc_clk_en, 1'h1);
    $display("Test config done");
    wrap_up();
  end
endmodule
